// file: hw/plc_param_block_parser.sv
`timescale 1ns/10ps
module plc_param_block_parser
   import param_pkg::*;
#(
   parameter int AW           = 8,         // program memory word address width
   parameter int MAX_WORDS    = 256,       // words searched for the end code
   parameter int FLASH_CYCLES = FLASH_CYC  // half period of display flashing
) (
   input  wire logic          clk,
   input  wire logic          resetn,
   // switch pins, asynchronous
   input  wire logic          run_sw,        // high = run position
   input  wire logic          mode_sw,       // high = interlink / store position
   input  wire logic [2:0]    seg_sel,       // host window selector
   // from the card's own logic
   input  wire logic          prog_loaded,   // a program is in ram
   input  wire logic          store_done,    // non-volatile save finished
   input  wire logic [19:0]   host_addr,     // host byte address
   // program memory read port, data one cycle after pm_rd
   output logic [AW-1:0]      pm_addr,
   output logic               pm_rd,
   input  wire logic [15:0]   pm_rdata,
   // software register port
   input  wire logic [3:0]    reg_addr,
   input  wire logic [15:0]   reg_wdata,
   input  wire logic          reg_wr,
   input  wire logic          reg_rd,
   output logic [15:0]        reg_rdata,
   // status
   output logic               plc_run,
   output logic               interlink_mode,
   output logic               store_req,
   output logic               parse_done,
   output logic [7:0]         error_number_output,
   output logic [7:0]         disp_value,
   output logic               disp_lit,
   output logic               dpram_sel,
   // applied configuration
   output logic [6:0]         func_en,
   output logic [7:0]         fin_start,
   output logic [8:0]         fin_count,
   output logic [7:0]         fout_start,
   output logic [8:0]         fout_count,
   output logic [15:0]        upd_mask,
   output logic [7:0]         rflag_start,
   output logic [8:0]         rflag_count,
   output logic [11:0]        rx_start,
   output logic [12:0]        rx_count,
   output logic [7:0]         rcnt_start,
   output logic [8:0]         rcnt_count,
   output logic [15:0]        cpl_block,
   output logic [2:0]         cpl_cards,
   output logic [5:0]         cpl_len
);

   localparam int SW = 5;                          // synchronised pin count
   localparam int FW = $clog2(FLASH_CYCLES + 1);   // flash counter width

   // refuse sizes the pointer, end search or flash timer cannot serve
   if (AW < 2 || MAX_WORDS < 4 || MAX_WORDS > (1 << AW) || FLASH_CYCLES < 1) begin : g_bad_param
      $error("plc_param_block_parser: unsupported parameter values");
   end

   typedef enum {S_IDLE, S_READ, S_WAIT, S_TAKE} fsm_t;
   typedef enum {G_HDR, G_CODE, G_PAR} stage_t;

   typedef struct packed {
      logic [6:0]  en;
      logic [7:0]  fin_s;
      logic [8:0]  fin_c;
      logic [7:0]  fout_s;
      logic [8:0]  fout_c;
      logic [15:0] upd;
      logic [7:0]  rf_s;
      logic [8:0]  rf_c;
      logic [11:0] rx_s;
      logic [12:0] rx_c;
      logic [7:0]  rc_s;
      logic [8:0]  rc_c;
      logic [15:0] cb;
      logic [2:0]  cc;
      logic [5:0]  cl;
   } cfg_t;

   typedef struct packed {
      fsm_t             st;        // parser sequencer
      stage_t           stage;     // what the next word means
      logic [AW-1:0]    ptr;       // word index in the block
      logic [1:0]       widx;      // word number inside a group
      logic [1:0]       need;      // parameters of current code
      logic [15:0]      code;      // current function code
      logic [1:0][15:0] par;       // first two parameters
      cfg_t             pend;      // collected during parse
      cfg_t             act;       // applied configuration
      logic             hdr_ok;    // header matched
      logic             done;      // parse finished
      logic [7:0]       err;       // error number
      logic             running;   // plc in run
      logic             storing;   // program save in progress
      logic             sreq;      // store request pulse
      logic             rd;        // memory read strobe
      logic [SW-1:0]    s1, s2, s3; // pin synchroniser stages
      logic [SW-1:0]    filt;      // debounced pin levels
      logic             run_prev;  // last filtered run switch
      logic             mode_prev; // last filtered mode switch
      logic [1:0]       boot_cnt;  // settle time before mode capture
      logic             booted;    // mode captured
      logic             ilink;     // interlink mode
      logic [15:0]      ctrl;      // software control word
      logic [15:0]      rdata;     // register read data
      logic [FW-1:0]    fcnt;      // flash timer
      logic             fph;       // flash phase
   } state_t;

   state_t q, d;

   // start + count must stay within the limit, start below it
   function automatic logic range_ok(input logic [15:0] s, input logic [15:0] c,
                                     input logic [16:0] lim);
      logic [16:0] sum;
      sum = {1'b0, s} + {1'b0, c};
      return ({1'b0, s} < lim) && (sum <= lim);
   endfunction

   // header word expected at a given position
   function automatic logic [15:0] hdr_word(input logic [1:0] i);
      case (i)
         2'd0:    return HDR_W0;
         2'd1:    return HDR_W1;
         default: return HDR_W2;
      endcase
   endfunction

   // parameters that follow each code, zero for an unknown one
   function automatic logic [1:0] par_count(input logic [15:0] c);
      case (c)
         CODE_FIN, CODE_FOUT, CODE_RFLAG, CODE_RX, CODE_RCNT: return 2'd2;
         CODE_UPD: return 2'd1;
         CODE_CPL: return 2'd3;
         default:  return 2'd0;
      endcase
   endfunction

   logic [19:0] win_base;   // byte base of the selected window
   assign win_base = {DP_BASE_SEG + 16'(q.filt[4:2]) * DP_SEG_STEP, 4'h0};

   // next-state logic for the whole block
   always_comb begin
      logic run_edge;
      logic store_edge;
      logic [15:0] w;
      logic [15:0] st;
      d = q;
      run_edge = 1'b0;
      store_edge = 1'b0;
      w = pm_rdata;
      st = 16'h0000;
      d.sreq = 1'b0;
      d.rd = 1'b0;

      // three-stage synchroniser; a level counts once stages two and three agree
      d.s1 = {seg_sel, mode_sw, run_sw};
      d.s2 = q.s1;
      d.s3 = q.s2;
      for (int i = 0; i < SW; i++) begin
         if (q.s2[i] == q.s3[i])
            d.filt[i] = q.s3[i];
      end

      // mode is taken once, after the synchroniser has settled past reset
      if (!q.booted) begin
         d.boot_cnt = q.boot_cnt + 2'd1;
         if (q.boot_cnt == 2'd3) begin
            d.booted = 1'b1;
            // take the level the filter settles to on this edge; the old one is still reset
            d.ilink = d.filt[1];
            d.mode_prev = d.filt[1];
            d.run_prev = d.filt[0];
         end
      end else begin
         d.run_prev = q.filt[0];
         d.mode_prev = q.filt[1];
         // the run edge only counts from a stopped switch, so a store leaves us stopped
         run_edge = q.filt[0] && !q.run_prev && !q.ilink;
         store_edge = q.filt[1] && !q.mode_prev && !q.ilink;
      end

      // run/stop handling
      if (!q.filt[0] || q.ctrl[CTRL_INHIBIT])
         d.running = 1'b0;
      if (store_edge && !q.storing) begin
         d.storing = 1'b1;
         d.sreq = 1'b1;
         d.running = 1'b0;
      end
      if (q.storing) begin
         d.running = 1'b0;
         if (store_done)
            d.storing = 1'b0;
      end

      // a stop-to-run edge restarts a parse; edits while running stay dormant
      if (run_edge && q.st == S_IDLE && !q.storing && prog_loaded &&
          !q.ctrl[CTRL_INHIBIT]) begin
         d.st = S_READ;
         d.stage = G_HDR;
         d.ptr = '0;
         d.widx = 2'd0;
         d.done = 1'b0;
         d.hdr_ok = 1'b0;
         d.err = ERR_NONE;
         d.pend = '0;
      end

      // parser sequencer: read, wait one cycle, take the word
      case (q.st)
         S_IDLE: begin
         end
         S_READ: begin
            d.rd = 1'b1;
            d.st = S_WAIT;
         end
         S_WAIT: begin
            d.st = S_TAKE;
         end
         S_TAKE: begin
            d.st = S_READ;
            d.ptr = q.ptr + AW'(1);
            case (q.stage)
               G_HDR: begin
                  if (w != hdr_word(q.widx)) begin
                     d.err = ERR_HDR;
                     d.st = S_IDLE;
                     d.done = 1'b1;
                  end else if (q.widx == 2'd2) begin
                     d.hdr_ok = 1'b1;
                     d.stage = G_CODE;
                  end else begin
                     d.widx = q.widx + 2'd1;
                  end
               end
               G_CODE: begin
                  if (w == CODE_END) begin
                     d.st = S_IDLE;
                     d.done = 1'b1;
                     d.act = q.pend;
                     // a store starting this cycle or an inhibit already set keeps the plc stopped
                     d.running = q.filt[0] && !d.storing && !q.ctrl[CTRL_INHIBIT];
                  end else if (par_count(w) == 2'd0) begin
                     d.err = ERR_CODE;
                     d.st = S_IDLE;
                     d.done = 1'b1;
                  end else begin
                     d.code = w;
                     d.need = par_count(w);
                     d.widx = 2'd0;
                     d.stage = G_PAR;
                  end
               end
               default: begin
                  if (q.widx != 2'd2)
                     d.par[q.widx[0]] = w;
                  if (q.widx == q.need - 2'd1) begin
                     d.stage = G_CODE;
                     case (q.code)
                        CODE_FIN: begin
                           if (range_ok(q.par[0], w, LIM_FLAG)) begin
                              d.pend.en[EN_FIN] = 1'b1;
                              d.pend.fin_s = q.par[0][7:0];
                              d.pend.fin_c = w[8:0];
                           end else d.err = ERR_RANGE;
                        end
                        CODE_FOUT: begin
                           if (range_ok(q.par[0], w, LIM_FLAG)) begin
                              d.pend.en[EN_FOUT] = 1'b1;
                              d.pend.fout_s = q.par[0][7:0];
                              d.pend.fout_c = w[8:0];
                           end else d.err = ERR_RANGE;
                        end
                        CODE_UPD: begin
                           d.pend.en[EN_UPD] = 1'b1;
                           d.pend.upd = w;
                        end
                        CODE_RFLAG: begin
                           if (range_ok(q.par[0], w, LIM_FLAG)) begin
                              d.pend.en[EN_RFLAG] = 1'b1;
                              d.pend.rf_s = q.par[0][7:0];
                              d.pend.rf_c = w[8:0];
                           end else d.err = ERR_RANGE;
                        end
                        CODE_RX: begin
                           if (range_ok(q.par[0], w, LIM_XFLAG)) begin
                              d.pend.en[EN_RX] = 1'b1;
                              d.pend.rx_s = q.par[0][11:0];
                              d.pend.rx_c = w[12:0];
                           end else d.err = ERR_RANGE;
                        end
                        CODE_RCNT: begin
                           if (range_ok(q.par[0], w, LIM_CNT)) begin
                              d.pend.en[EN_RCNT] = 1'b1;
                              d.pend.rc_s = q.par[0][7:0];
                              d.pend.rc_c = w[8:0];
                           end else d.err = ERR_RANGE;
                        end
                        default: begin
                           // card coupling: block, cards, length
                           if (q.par[1] <= MAX_CARDS && w <= MAX_LEN) begin
                              d.pend.en[EN_CPL] = 1'b1;
                              d.pend.cb = q.par[0];
                              d.pend.cc = q.par[1][2:0];
                              d.pend.cl = w[5:0];
                           end else d.err = ERR_RANGE;
                        end
                     endcase
                     // a faulty entry ends the parse and nothing is applied
                     if (d.err != ERR_NONE) begin
                        d.st = S_IDLE;
                        d.done = 1'b1;
                     end
                  end else begin
                     d.widx = q.widx + 2'd1;
                  end
               end
            endcase
            // ran off the searched area without an end code
            if (d.st == S_READ && q.ptr == AW'(MAX_WORDS - 1)) begin
               d.err = ERR_NOEND;
               d.st = S_IDLE;
               d.done = 1'b1;
            end
         end
         default: d.st = S_IDLE;
      endcase

      // display flash timer, free running
      if (q.fcnt == FW'(FLASH_CYCLES - 1)) begin
         d.fcnt = '0;
         d.fph = !q.fph;
      end else begin
         d.fcnt = q.fcnt + FW'(1);
      end

      // software register port
      st[ST_DONE] = q.done;
      st[ST_HDROK] = q.hdr_ok;
      st[ST_ERR] = (q.err != ERR_NONE);
      st[ST_RUN] = q.running;
      st[ST_STORE] = q.storing;
      st[ST_ILINK] = q.ilink;
      st[ST_NOPROG] = !prog_loaded;
      if (reg_wr && reg_addr == REG_CTRL)
         d.ctrl = {15'h0000, reg_wdata[CTRL_INHIBIT]};
      d.rdata = 16'h0000;
      if (reg_rd) begin
         case (reg_addr)
            REG_STATUS: d.rdata = st;
            REG_ERROR:  d.rdata = {8'h00, q.err};
            REG_CTRL:   d.rdata = q.ctrl;
            REG_ENABLE: d.rdata = {9'h000, q.act.en};
            REG_UPD:    d.rdata = q.act.upd;
            default:    d.rdata = 16'h0000;
         endcase
      end
   end

   // single state register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         q <= '{st: S_IDLE, stage: G_HDR, default: '0};
      end else begin
         q <= d;
      end
   end

   // outputs
   assign pm_addr = q.ptr;
   assign pm_rd = q.rd;
   assign reg_rdata = q.rdata;
   assign plc_run = q.running;
   assign interlink_mode = q.ilink;
   assign store_req = q.sreq;
   assign parse_done = q.done;
   assign error_number_output = q.err;
   // host window match on the top address bits
   assign dpram_sel = (host_addr[19:DP_WIN_BITS] == win_base[19:DP_WIN_BITS]);

   // status display: interlink (shown as stop) beats store beats no-program beats run/stop
   always_comb begin
      disp_value = q.running ? DISP_RUN : DISP_STOP;
      disp_lit = q.booted;
      if (q.ilink) begin
         disp_value = DISP_STOP;
      end else if (q.storing) begin
         disp_value = DISP_STORE;
         disp_lit = q.fph;
      end else if (q.booted && !prog_loaded) begin
         disp_value = DISP_NOPRG;
         disp_lit = q.fph;
      end
   end

   // applied configuration, only changed by a clean parse
   assign func_en = q.act.en;
   assign fin_start = q.act.fin_s;
   assign fin_count = q.act.fin_c;
   assign fout_start = q.act.fout_s;
   assign fout_count = q.act.fout_c;
   assign upd_mask = q.act.upd;
   assign rflag_start = q.act.rf_s;
   assign rflag_count = q.act.rf_c;
   assign rx_start = q.act.rx_s;
   assign rx_count = q.act.rx_c;
   assign rcnt_start = q.act.rc_s;
   assign rcnt_count = q.act.rc_c;
   assign cpl_block = q.act.cb;
   assign cpl_cards = q.act.cc;
   assign cpl_len = q.act.cl;

endmodule

// file: hw/param_pkg.sv
package param_pkg;
   // header words spelling the block identifier
   localparam logic [15:0] HDR_W0     = 16'h4d41;
   localparam logic [15:0] HDR_W1     = 16'h534b;
   localparam logic [15:0] HDR_W2     = 16'h3031;
   // function codes and terminator
   localparam logic [15:0] CODE_FIN   = 16'hce00;
   localparam logic [15:0] CODE_FOUT  = 16'hca00;
   localparam logic [15:0] CODE_UPD   = 16'hcc00;
   localparam logic [15:0] CODE_RFLAG = 16'hcb00;
   localparam logic [15:0] CODE_RX    = 16'hcb01;
   localparam logic [15:0] CODE_RCNT  = 16'hcb02;
   localparam logic [15:0] CODE_CPL   = 16'hcd00;
   localparam logic [15:0] CODE_END   = 16'heeee;
   // range limits (start max is limit minus one)
   localparam logic [16:0] LIM_FLAG   = 17'h00100;
   localparam logic [16:0] LIM_XFLAG  = 17'h01000;
   localparam logic [16:0] LIM_CNT    = 17'h00100;
   localparam logic [15:0] MAX_CARDS  = 16'h0007;
   localparam logic [15:0] MAX_LEN    = 16'h0020;
   // error numbers
   localparam logic [7:0]  ERR_NONE   = 8'h00;
   localparam logic [7:0]  ERR_HDR    = 8'h01;
   localparam logic [7:0]  ERR_RANGE  = 8'h02;
   localparam logic [7:0]  ERR_CODE   = 8'h03;
   localparam logic [7:0]  ERR_NOEND  = 8'h04;
   // enable bit positions, one per function sub-block
   localparam int EN_FIN = 0, EN_FOUT = 1, EN_UPD = 2, EN_RFLAG = 3;
   localparam int EN_RX = 4, EN_RCNT = 5, EN_CPL = 6;
   // register indices on the software port
   localparam logic [3:0]  REG_STATUS = 4'h0;
   localparam logic [3:0]  REG_ERROR  = 4'h1;
   localparam logic [3:0]  REG_CTRL   = 4'h2;
   localparam logic [3:0]  REG_ENABLE = 4'h3;
   localparam logic [3:0]  REG_UPD    = 4'h4;
   // status and control bit positions
   localparam int ST_DONE = 0, ST_HDROK = 1, ST_ERR = 2, ST_RUN = 3;
   localparam int ST_STORE = 4, ST_ILINK = 5, ST_NOPROG = 6;
   localparam int CTRL_INHIBIT = 0;
   // status display codes, two hex digits
   localparam logic [7:0]  DISP_RUN   = 8'h01;
   localparam logic [7:0]  DISP_STOP  = 8'h00;
   localparam logic [7:0]  DISP_STORE = 8'h80;
   localparam logic [7:0]  DISP_NOPRG = 8'hee;
   // host memory window
   localparam logic [15:0] DP_BASE_SEG = 16'hd000;
   localparam logic [15:0] DP_SEG_STEP = 16'h0200;
   localparam int          DP_WIN_BITS = 13;
   // timing
   localparam int CLK_HZ        = 20_000_000;
   localparam int FLASH_HALF_MS = 250;
   localparam int FLASH_CYC     = FLASH_HALF_MS * (CLK_HZ / 1000);
endpackage

// file: tb/pm_model.sv
`timescale 1ns/10ps
// program memory holding the parameter block
module pm_model (
   input  wire logic        clk,
   input  wire logic [7:0]  pm_addr,
   input  wire logic        pm_rd,
   output logic      [15:0] pm_rdata
);
   logic [15:0] mem [0:255]; // block words, loaded by the bench
   // answer one cycle after the strobe; otherwise invert, so a late sample sees junk
   always_ff @(posedge clk) begin
      if (pm_rd) begin
         pm_rdata <= mem[pm_addr];
      end else begin
         pm_rdata <= ~pm_rdata;
      end
   end
endmodule

// file: tb/plc_param_block_parser_checker.sv
`timescale 1ns/10ps
module plc_param_block_parser_checker
   import param_pkg::*;
(
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic        pm_rd,
   input wire logic        plc_run,
   input wire logic        store_req,
   input wire logic        parse_done,
   input wire logic        dpram_sel,
   input wire logic [7:0]  error_number_output,
   input wire logic [7:0]  disp_value,
   input wire logic [6:0]  func_en,
   input wire logic [2:0]  seg_sel,
   input wire logic [19:0] host_addr
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   property p_gap; pm_rd |=> !pm_rd ##1 !pm_rd; endproperty
   a_gap: assert property (p_gap) else $error("reads too close");
   property p_busy; pm_rd |-> !parse_done; endproperty
   a_busy: assert property (p_busy) else $error("read after done");
   property p_rund; plc_run |-> disp_value == DISP_RUN; endproperty
   a_rund: assert property (p_rund) else $error("run display");
   property p_st; store_req |=> !plc_run && disp_value == DISP_STORE; endproperty
   a_st: assert property (p_st) else $error("store display");
   property p_es; $rose(parse_done) && error_number_output != ERR_NONE |-> !plc_run; endproperty
   a_es: assert property (p_es) else $error("ran on error");
   property p_ok; $rose(parse_done) && error_number_output == ERR_NONE |-> plc_run; endproperty
   a_ok: assert property (p_ok) else $error("no run");
   property p_cf; !$stable(func_en) |-> $rose(parse_done) && error_number_output == ERR_NONE;
   endproperty
   a_cf: assert property (p_cf) else $error("config moved");
   property p_hd; $rose(parse_done) && error_number_output == ERR_HDR |-> $stable(func_en);
   endproperty
   a_hd: assert property (p_hd) else $error("bad header applied");
   property p_win;
      $stable(seg_sel) [*6] |-> dpram_sel == (host_addr[19:13] == 7'h68 + {4'h0, seg_sel});
   endproperty
   a_win: assert property (p_win) else $error("window decode");
endmodule
bind plc_param_block_parser plc_param_block_parser_checker u_chk (.clk, .resetn, .pm_rd,
   .plc_run, .store_req, .parse_done, .dpram_sel, .error_number_output, .disp_value,
   .func_en, .seg_sel, .host_addr);

// file: tb/tb_plc_param_block_parser.sv
`timescale 1ns/10ps
module tb_plc_param_block_parser;
   import param_pkg::*;
   logic clk = 1'b0, resetn = 1'b0, run_sw = 1'b0, mode_sw = 1'b0, prog_loaded = 1'b0;
   logic store_done = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, f;
   logic [2:0] seg_sel = 3'h0, cpl_cards;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000, pm_rdata, reg_rdata, upd_mask, cpl_block, d;
   logic [19:0] host_addr = 20'h00000;
   logic [7:0] pm_addr, error_number_output, disp_value, fin_start, fout_start, rflag_start;
   logic [7:0] rcnt_start;
   logic [8:0] fin_count, fout_count, rflag_count, rcnt_count;
   logic pm_rd, plc_run, interlink_mode, store_req, parse_done, disp_lit, dpram_sel;
   logic [6:0] func_en;
   logic [11:0] rx_start;
   logic [12:0] rx_count;
   logic [5:0] cpl_len;
   int fail_count = 0, checks_done = 0, k;
   always #25 clk = ~clk;
   plc_param_block_parser #(.MAX_WORDS(32), .FLASH_CYCLES(4)) DUT (.*);
   pm_model u_pm (.clk(clk), .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_rdata(pm_rdata));
   task chk(input string n, input logic [31:0] s, e);
      checks_done++;
      if (s !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task finish_test();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // header plus body; the tail repeats the last word so no stray end code appears
   task ld(input logic [15:0] b[$], input logic bad);
      logic [15:0] q[$];
      q = {HDR_W0, HDR_W1, HDR_W2 ^ {15'h0, bad}, b};
      for (k = 0; k < 256; k++) u_pm.mem[k] = k < q.size() ? q[k] : q[q.size() - 1];
   endtask
   task okb();
      ld('{CODE_CPL, 16'h0009, 16'h0007, 16'h0020, CODE_UPD, 16'h7fff, CODE_RFLAG, 16'h0032,
         16'h000a, CODE_FIN, 16'h0000, 16'h0100, CODE_FOUT, 16'h00ff, 16'h0001, CODE_RX,
         16'h0fff, 16'h0001, CODE_RCNT, 16'h00fe, 16'h0002, CODE_END}, 1'b0);
   endtask
   // stop then run, then wait for the parse to finish
   task go();
      @(posedge clk);
      run_sw <= 1'b0;
      cyc(8);
      run_sw <= 1'b1;
      for (k = 0; k < 40 && parse_done !== 1'b0; k++) @(negedge clk);
      for (k = 0; k < 400 && parse_done !== 1'b1; k++) @(negedge clk);
   endtask
   task rd(input logic [3:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      d = reg_rdata;
   endtask
   // one write cycle on the register port
   task wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // boot in plc mode with no program loaded
   task test_boot();
      cyc(10);
      resetn <= 1'b1;
      cyc(12);
      @(negedge clk);
      chk("noprog", disp_value, DISP_NOPRG);
      f = disp_lit;
      cyc(4);
      @(negedge clk);
      chk("flash", disp_lit, !f);
      $display("test boot done");
   endtask
   task test_hdr();
      @(posedge clk);
      prog_loaded <= 1'b1;
      ld('{CODE_END}, 1'b1);
      go();
      chk("hdr", error_number_output, ERR_HDR);
      chk("hdr en", func_en, 7'h00);
      $display("test header done");
   endtask
   task test_good();
      okb();
      go();
      chk("err", error_number_output, ERR_NONE);
      chk("en", func_en, 7'h7f);
      chk("fin", {fin_start, fin_count}, {8'h00, 9'h100});
      chk("fout", {fout_start, fout_count}, {8'hff, 9'h001});
      chk("upd", upd_mask, 16'h7fff);
      chk("rflag", {rflag_start, rflag_count}, {8'h32, 9'h00a});
      chk("rx", {rx_start, rx_count}, {12'hfff, 13'h0001});
      chk("rcnt", {rcnt_start, rcnt_count}, {8'hfe, 9'h002});
      chk("cpl", {cpl_block, cpl_cards, cpl_len}, {16'h0009, 3'h7, 6'h20});
      chk("disp", disp_value, DISP_RUN);
      rd(4'hf);
      chk("unmapped", d, 16'h0000);
      // the mask register is read only; this write must be ignored
      wr(REG_UPD, 16'h1234);
      rd(REG_UPD);
      chk("upd reg", d, 16'h7fff);
      ld('{CODE_UPD, 16'h0001, CODE_END}, 1'b0);
      cyc(40);
      chk("no edit", upd_mask, 16'h7fff);
      $display("test good block done");
   endtask
   // every fault stops the parse and leaves the applied set alone
   task test_faults();
      logic [7:0] ex;
      for (int i = 0; i < 8; i++) begin
         case (i)
            0: ld('{CODE_FIN, 16'h00c8, 16'h0039, CODE_END}, 1'b0);
            1: ld('{CODE_FOUT, 16'h0100, 16'h0000, CODE_END}, 1'b0);
            2: ld('{CODE_RX, 16'h0000, 16'h1001, CODE_END}, 1'b0);
            3: ld('{CODE_RCNT, 16'h00ff, 16'h0002, CODE_END}, 1'b0);
            4: ld('{CODE_RFLAG, 16'h0032, 16'h00cf, CODE_END}, 1'b0);
            5: ld('{CODE_CPL, 16'h0001, 16'h0008, 16'h0020, CODE_END}, 1'b0);
            6: ld('{16'hcf00, CODE_END}, 1'b0);
            default: ld('{CODE_UPD}, 1'b0);
         endcase
         go();
         ex = i < 6 ? ERR_RANGE : i == 6 ? ERR_CODE : ERR_NOEND;
         chk("errnum", error_number_output, ex);
         chk("keep", func_en, 7'h7f);
         chk("stop", plc_run, 1'b0);
      end
      $display("test faults done");
   endtask
   task test_store();
      okb();
      go();
      @(posedge clk);
      mode_sw <= 1'b1;
      for (k = 0; k < 20 && store_req !== 1'b1; k++) @(negedge clk);
      chk("store", store_req, 1'b1);
      @(negedge clk);
      chk("store run", {disp_value, plc_run}, {DISP_STORE, 1'b0});
      f = disp_lit;
      cyc(4);
      @(negedge clk);
      chk("store flash", disp_lit, !f);
      @(posedge clk);
      store_done <= 1'b1;
      @(posedge clk);
      store_done <= 1'b0;
      mode_sw <= 1'b0;
      cyc(10);
      @(negedge clk);
      chk("stored", {disp_value, 7'h00, plc_run}, {DISP_STOP, 8'h00});
      go();
      chk("restart", plc_run, 1'b1);
      $display("test store done");
   endtask
   // software inhibit forces stop and refuses a restart
   task test_ctrl();
      wr(REG_CTRL, 16'h0001);
      rd(REG_CTRL);
      chk("ctrl", d, 16'h0001);
      rd(REG_STATUS);
      chk("status", d, 16'h0003);
      chk("inhibit", plc_run, 1'b0);
      go();
      chk("blocked", {parse_done, plc_run}, 2'b10);
      rd(REG_ENABLE);
      chk("enable", d, 16'h007f);
      wr(REG_CTRL, 16'h0000);
      $display("test control done");
   endtask
   task test_window();
      for (int s = 0; s < 8; s++) begin
         @(posedge clk);
         seg_sel <= s[2:0];
         host_addr <= {7'h68 + s[6:0], 13'h1fff};
         cyc(8);
         @(negedge clk);
         chk("win in", dpram_sel, 1'b1);
         @(posedge clk);
         host_addr <= {7'h69 + s[6:0], 13'h0000};
         @(negedge clk);
         chk("win out", dpram_sel, 1'b0);
      end
      $display("test window done");
   endtask
   // reset first, then move the mode switch, then release
   task test_mode();
      @(posedge clk);
      seg_sel <= 3'h0;
      cyc(8);
      resetn <= 1'b0;
      cyc(1);
      mode_sw <= 1'b1;
      cyc(10);
      resetn <= 1'b1;
      cyc(10);
      @(negedge clk);
      chk("ilink", interlink_mode, 1'b1);
      $display("test mode done");
   endtask
   initial begin
      test_boot();
      test_hdr();
      test_good();
      test_faults();
      test_store();
      test_ctrl();
      test_window();
      test_mode();
      finish_test();
   end
   // cut a hang short
   initial begin
      cyc(30000);
      fail_count++;
      finish_test();
   end
endmodule
